// ===== design/pio_port.sv
// Functional notes
// - output mode drives pin from output latch, or from addr_out_value when the function select bit is 1
// - direction bit: 0 input, 1 output
// - drive bit: 0 push-pull, 1 open-drain/slew
// - macrocell register reads held macrocell values
// - enable status reads live output enables
// - registers decoded at base plus offset
`timescale 1ns/1ps

module pio_port
    import pio_pkg::*;
#(
    parameter int PINS = pio_pkg::PIO_PINS
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic [pio_pkg::PIO_ADDR_W-1:0] io_block_base,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pio_pkg::PIO_ADDR_W-1:0] paddr,
    input  wire logic [pio_pkg::PIO_DATA_W-1:0] pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [pio_pkg::PIO_DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [PINS-1:0]               pin_in,
    output logic      [PINS-1:0]               pin_out,
    output logic      [PINS-1:0]               pin_oe,
    output logic      [PINS-1:0]               pin_slew_sel,
    input  wire logic [PINS-1:0]               mcell_value,
    input  wire logic [PINS-1:0]               addr_out_value
);
    import pio_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [PINS-1:0]            pin_function_select;
    logic [PINS-1:0]            output_latch;
    logic [PINS-1:0]            pin_direction;
    logic [PINS-1:0]            pin_drive_type;
    logic [PINS-1:0]            mcell_hold;
    logic [PINS-1:0]            pin_level;
    logic [PINS-1:0]            next_pin_function_select;
    logic [PINS-1:0]            next_output_latch;
    logic [PINS-1:0]            next_pin_direction;
    logic [PINS-1:0]            next_pin_drive_type;
    logic [PINS-1:0]            next_mcell_hold;
    logic [PINS-1:0]            next_pin_out;
    logic [PINS-1:0]            next_pin_oe;
    logic [PINS-1:0]            next_pin_slew_sel;
    logic [PIO_DATA_W-1:0]      next_prdata;
    logic                       next_pready;
    logic                       next_pslverr;
    logic [PIO_ADDR_W-1:0]      rel_addr;
    logic                       addr_hit;
    logic [3:0]                 reg_idx;
    logic                       reg_known;
    logic [PINS-1:0]            rd_byte;
    logic                       wr_fire;

    // ****************************************
    // pin sampling
    // ****************************************
    // pins are asynchronous, two flops before any reader
    pio_sync #(
        .WIDTH    (PINS)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (pin_in),
        .sync_out (pin_level)
    );

    // ****************************************
    // address decode
    // ****************************************
    // relative offset from the configured base, word aligned only
    always_comb begin
        rel_addr  = paddr - io_block_base;
        addr_hit  = (rel_addr[PIO_ADDR_W-1:IDX_MSB+1] == '0)
                    && (rel_addr[IDX_LSB-1:0] == '0);
        reg_idx   = rel_addr[IDX_MSB:IDX_LSB];
        unique case (reg_idx)
            IDX_PIN_INPUT_VALUE,
            IDX_PIN_FUNCTION_SELECT,
            IDX_OUTPUT_LATCH,
            IDX_PIN_DIRECTION,
            IDX_PIN_DRIVE_TYPE,
            IDX_INPUT_LATCH_READBACK,
            IDX_OUTPUT_ENABLE_STATUS: reg_known = addr_hit;
            default:                  reg_known = 1'b0;
        endcase
    end

    // read mux; unused bits above the byte read as zero
    always_comb begin
        unique case (reg_idx)
            IDX_PIN_INPUT_VALUE:      rd_byte = pin_level;
            IDX_PIN_FUNCTION_SELECT:  rd_byte = pin_function_select;
            IDX_OUTPUT_LATCH:         rd_byte = output_latch;
            IDX_PIN_DIRECTION:        rd_byte = pin_direction;
            IDX_PIN_DRIVE_TYPE:       rd_byte = pin_drive_type;
            IDX_INPUT_LATCH_READBACK: rd_byte = mcell_hold;
            IDX_OUTPUT_ENABLE_STATUS: rd_byte = pin_oe;
            default:                  rd_byte = RST_PIN_BYTE;
        endcase
    end

    // ****************************************
    // apb handshake
    // ****************************************
    // one wait state: ready registered, so access phase is two cycles
    always_comb begin
        next_pready  = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_prdata  = RST_WORD;
        if (next_pready) begin
            next_pslverr = !reg_known;
            if (!pwrite && reg_known) begin
                next_prdata = {{(PIO_DATA_W-PINS){1'b0}}, rd_byte};
            end
        end
    end

    // write commits only on the edge that completes the access
    assign wr_fire = psel && penable && pready && pwrite && reg_known && pstrb[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RST_WORD;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // read-only indices fall through, so data-in writes vanish
    always_comb begin
        next_pin_function_select = pin_function_select;
        next_output_latch        = output_latch;
        next_pin_direction       = pin_direction;
        next_pin_drive_type      = pin_drive_type;
        if (wr_fire) begin
            unique case (reg_idx)
                IDX_PIN_FUNCTION_SELECT: next_pin_function_select = pwdata[PINS-1:0];
                IDX_OUTPUT_LATCH:        next_output_latch        = pwdata[PINS-1:0];
                IDX_PIN_DIRECTION:       next_pin_direction       = pwdata[PINS-1:0];
                IDX_PIN_DRIVE_TYPE:      next_pin_drive_type      = pwdata[PINS-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_function_select <= RST_PIN_FUNCTION_SELECT;
            output_latch        <= RST_OUTPUT_LATCH;
            pin_direction       <= RST_PIN_DIRECTION;
            pin_drive_type      <= RST_PIN_DRIVE_TYPE;
        end else begin
            pin_function_select <= next_pin_function_select;
            output_latch        <= next_output_latch;
            pin_direction       <= next_pin_direction;
            pin_drive_type      <= next_pin_drive_type;
        end
    end

    // ****************************************
    // pin drivers and macrocell capture
    // ****************************************
    // open drain only pulls low; a high bit releases the pin.
    // slew is a pad option, so drive bit is also passed to the pad.
    always_comb begin
        logic src;
        src             = 1'b0;
        next_mcell_hold = mcell_value;
        for (int i = 0; i < PINS; i++) begin
            src = (pin_function_select[i] == FUNC_IO) ? output_latch[i]
                                                      : addr_out_value[i];
            next_pin_slew_sel[i] = pin_drive_type[i];
            if (pin_direction[i] == DIR_INPUT) begin
                next_pin_out[i] = 1'b0;
                next_pin_oe[i]  = 1'b0;
            end else if (pin_drive_type[i] == DRV_CMOS) begin
                next_pin_out[i] = src;
                next_pin_oe[i]  = 1'b1;
            end else begin
                next_pin_out[i] = 1'b0;
                next_pin_oe[i]  = !src;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out      <= RST_PIN_BYTE;
            pin_oe       <= RST_PIN_BYTE;
            pin_slew_sel <= RST_PIN_BYTE;
            mcell_hold   <= RST_PIN_BYTE;
        end else begin
            pin_out      <= next_pin_out;
            pin_oe       <= next_pin_oe;
            pin_slew_sel <= next_pin_slew_sel;
            mcell_hold   <= next_mcell_hold;
        end
    end

endmodule : pio_port

// ===== design/pio_pkg.sv
package pio_pkg;

    // ****************************************
    // port geometry and bus
    // ****************************************
    localparam int          PIO_PINS      = 8;
    localparam int          PIO_ADDR_W    = 32;
    localparam int          PIO_DATA_W    = 32;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [3:0]  IDX_PIN_INPUT_VALUE      = 4'h0;
    localparam logic [3:0]  IDX_PIN_FUNCTION_SELECT  = 4'h2;
    localparam logic [3:0]  IDX_OUTPUT_LATCH         = 4'h4;
    localparam logic [3:0]  IDX_PIN_DIRECTION        = 4'h6;
    localparam logic [3:0]  IDX_PIN_DRIVE_TYPE       = 4'h8;
    localparam logic [3:0]  IDX_INPUT_LATCH_READBACK = 4'ha;
    localparam logic [3:0]  IDX_OUTPUT_ENABLE_STATUS = 4'hc;

    // index sits in byte address bits [5:2]
    localparam int          IDX_LSB       = 2;
    localparam int          IDX_MSB       = 5;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]  RST_PIN_FUNCTION_SELECT = 8'h00;
    localparam logic [7:0]  RST_OUTPUT_LATCH        = 8'h00;
    localparam logic [7:0]  RST_PIN_DIRECTION       = 8'h00;
    localparam logic [7:0]  RST_PIN_DRIVE_TYPE      = 8'h00;
    localparam logic [7:0]  RST_PIN_BYTE            = 8'h00;
    localparam logic [31:0] RST_WORD                = 32'h0000_0000;

    // ****************************************
    // field values
    // ****************************************
    localparam logic        DIR_INPUT     = 1'b0;
    localparam logic        DRV_CMOS      = 1'b0;
    localparam logic        FUNC_IO       = 1'b0;

endpackage : pio_pkg

// ===== design/pio_sync.sv
`timescale 1ns/1ps

// ****************************************
// two-stage synchroniser for pin levels
// ****************************************
module pio_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // first stage feeds only the second stage
    always_comb begin
        next_meta     = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync_out;
        end
    end

endmodule : pio_sync

// ===== verification/pio_port_asserts.sv
`timescale 1ns/1ps

// ****************************************
// port a checker
// ****************************************
module pio_port_chk
    import pio_pkg::*;
#(
    parameter int PINS = pio_pkg::PIO_PINS
) (
    input wire logic                            sys_clk,
    input wire logic                            rst_n,
    input wire logic [pio_pkg::PIO_ADDR_W-1:0] io_block_base,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [pio_pkg::PIO_ADDR_W-1:0] paddr,
    input wire logic [pio_pkg::PIO_DATA_W-1:0] pwdata,
    input wire logic [3:0]                      pstrb,
    input wire logic [pio_pkg::PIO_DATA_W-1:0] prdata,
    input wire logic                            pready,
    input wire logic                            pslverr,
    input wire logic [PINS-1:0]                 pin_in,
    input wire logic [PINS-1:0]                 pin_out,
    input wire logic [PINS-1:0]                 pin_oe,
    input wire logic [PINS-1:0]                 pin_slew_sel,
    input wire logic [PINS-1:0]                 mcell_value,
    input wire logic [PINS-1:0]                 addr_out_value
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // good read answer, data qualified
    logic rd_ok;
    assign rd_ok = pready && !pwrite && !pslverr;
    sequence s_taken;
        psel && penable && !pready;
    endsequence
    a_ready_next: assert property (s_taken |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_unmapped_err: assert property (pready && paddr == io_block_base + 32'h0000_0004 |-> pslverr)
        else $error("unmapped offset without error");
    a_ro_no_err: assert property (pready && pwrite && paddr == io_block_base |-> !pslverr)
        else $error("write to input value flagged");
    a_reset_input: assert property ($rose(rst_n) |-> pin_oe == '0)
        else $error("pin driven after reset");
    a_out_needs_oe: assert property ((pin_out & ~pin_oe) == '0)
        else $error("high pin value while not driving");
    // read data was registered one edge earlier, so compare with the enables seen then
    a_oe_readback: assert property (rd_ok && paddr == io_block_base + 32'h0000_0030
        |-> prdata[PINS-1:0] == $past(pin_oe))
        else $error("enable status differs from pin_oe");
    a_mcell_read: assert property (rd_ok && paddr == io_block_base + 32'h0000_0028
        |-> prdata[PINS-1:0] == $past(mcell_value, 2))
        else $error("macrocell readback differs");
endmodule : pio_port_chk

bind pio_port pio_port_chk #(.PINS(PINS)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .io_block_base(io_block_base), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_slew_sel(pin_slew_sel), .mcell_value(mcell_value), .addr_out_value(addr_out_value));

// ===== verification/pio_ext.sv
`timescale 1ns/1ps

// ****************************************
// circuitry on the port pins
// ****************************************
module pio_ext #(
    parameter int PINS = 8
) (
    input  wire logic [PINS-1:0] pin_out,
    input  wire logic [PINS-1:0] pin_oe,
    input  wire logic [PINS-1:0] ext_en,
    input  wire logic [PINS-1:0] ext_val,
    output logic      [PINS-1:0] pin_in
);
    // pull-up wins on lines nobody drives, so released pins never echo old data
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule : pio_ext

// ===== verification/tb_top.sv
`timescale 1ns/1ps

// ****************************************
// port a register bench
// ****************************************
module tb_top;
    import pio_pkg::*;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [31:0] io_block_base, paddr, pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_slew_sel, mcell_value, addr_out_value;
    logic [7:0]  ext_en, ext_val;
    int          num_errors, n_compared;

    pio_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .io_block_base(io_block_base),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_slew_sel(pin_slew_sel),
        .mcell_value(mcell_value), .addr_out_value(addr_out_value));
    pio_ext u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer; an idle edge first so psel is never assigned twice at one edge
    task automatic xfer(input logic w, input logic [31:0] off, input logic [31:0] wd,
                        input logic err);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= io_block_base + off;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rd = prdata;
        chk("pslverr", 32'(pslverr), 32'(err));
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rchk(input string nm, input logic [31:0] off, input logic [31:0] exp);
        xfer(1'b0, off, 32'h0000_0000, 1'b0);
        chk(nm, rd, exp);
    endtask : rchk

    // pins settle one edge after the register, a few spare edges cost nothing
    task automatic pins(input logic [7:0] out, input logic [7:0] oe);
        repeat (4) @(posedge sys_clk);
        chk("pin_out", 32'(pin_out), 32'(out));
        chk("pin_oe", 32'(pin_oe), 32'(oe));
    endtask : pins

    task automatic results();
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // hang guard, tests need well under 2000 cycles
    initial begin
        #100_000;
        num_errors++;
        results();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        io_block_base  = 32'h0000_0100;
        pstrb          = 4'hf;
        mcell_value    = 8'h00;
        addr_out_value = 8'h00;
        ext_en         = 8'h00;
        ext_val        = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        pins(8'h00, 8'h00);
        rchk("pins_up", 32'h0000_0000, 32'h0000_00ff);
        for (int i = 1; i < 5; i++) rchk("rst", 32'(i * 8), 32'h0000_0000);
        rchk("oe_stat", 32'h0000_0030, 32'h0000_0000);
        xfer(1'b1, 32'h0000_0018, 32'h0000_00ff, 1'b0);
        xfer(1'b1, 32'h0000_0010, 32'h0000_00a5, 1'b0);
        pins(8'ha5, 8'hff);
        rchk("oe_stat", 32'h0000_0030, 32'h0000_00ff);
        rchk("pins_out", 32'h0000_0000, 32'h0000_00a5);
        addr_out_value <= 8'h3c;
        xfer(1'b1, 32'h0000_0008, 32'h0000_000f, 1'b0);
        rchk("func", 32'h0000_0008, 32'h0000_000f);
        pins(8'hac, 8'hff);
        xfer(1'b1, 32'h0000_0008, 32'h0000_0000, 1'b0);
        xfer(1'b1, 32'h0000_0020, 32'h0000_000f, 1'b0);
        pins(8'ha0, 8'hfa);
        chk("slew", 32'(pin_slew_sel), 32'h0000_000f);
        rchk("od_pins", 32'h0000_0000, 32'h0000_00a5);
        pstrb <= 4'h0;
        xfer(1'b1, 32'h0000_0010, 32'h0000_0000, 1'b0);
        pstrb <= 4'hf;
        rchk("latch", 32'h0000_0010, 32'h0000_00a5);
        xfer(1'b1, 32'h0000_0018, 32'h0000_0000, 1'b0);
        ext_en  <= 8'hff;
        ext_val <= 8'h3c;
        pins(8'h00, 8'h00);
        xfer(1'b1, 32'h0000_0000, 32'h0000_00ff, 1'b0);
        rchk("pins_in", 32'h0000_0000, 32'h0000_003c);
        rchk("oe_stat", 32'h0000_0030, 32'h0000_0000);
        mcell_value <= 8'h5a;
        rchk("mcell", 32'h0000_0028, 32'h0000_005a);
        xfer(1'b1, 32'h0000_0004, 32'h0000_00ff, 1'b1);
        xfer(1'b0, 32'h0000_003c, 32'h0000_0000, 1'b1);
        chk("err_data", rd, 32'h0000_0000);
        // mid-run reset while pins drive: everything must fall back to inputs
        xfer(1'b1, 32'h0000_0018, 32'h0000_00ff, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        pins(8'h00, 8'h00);
        rchk("dir_rst", 32'h0000_0018, 32'h0000_0000);
        rchk("latch_rst", 32'h0000_0010, 32'h0000_0000);
        rchk("pins_rst", 32'h0000_0000, 32'h0000_003c);
        results();
    end
endmodule : tb_top
